// [core/diag_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

`define ADDR_FLASH_CNT 6'h00
`define ADDR_ALM1_THR 6'h20
`define ADDR_ALM2_THR 6'h22
`define ADDR_ALM1_SMPL 6'h24
`define ADDR_ALM2_SMPL 6'h26
`define ADDR_ALARM_CONTROL 6'h28
`define ADDR_DIAG_CTRL 6'h34
`define ADDR_ERR_FLAGS 6'h3c

`define FR_WRITE 15
`define FR_ADDR_HI 13
`define FR_ADDR_LO 8

`define DC_DR_LINE 0
`define DC_DR_POL 1
`define DC_DR_EN 2
`define DC_EXT_POS 8
`define DC_EXT_NEG 9
`define DC_INT_TEST 10

`define EF_SUP_LOW 0
`define EF_SUP_HIGH 1
`define EF_CTRL_FAIL 2
`define EF_COMM_FAIL 3
`define EF_OVER_RANGE 4
`define EF_SELF_TEST 5
`define EF_ALM1 8
`define EF_ALM2 9

`define AC_LINE 0
`define AC_POL 1
`define AC_EN 2
`define AC_FILT 4
`define AC_SRC1_LO 8
`define AC_ROC1 11
`define AC_SRC2_LO 12
`define AC_ROC2 15

`define THR_DIR 15
`define THR_MAG_HI 13

`define SRC_SUPPLY 3'h1
`define SRC_GYRO 3'h2
`define SRC_AUX 3'h5
`define SRC_TEMP 3'h6

`define DIAG_MASK 16'h0307
`define ALARM_CONTROL_MASK 16'hff17
`define THR_MASK 16'hbfff
`define SMPL_MASK 16'h00ff
`define REG_RESET 16'h0000

`define CLK_PERIOD_NS 50
`define DR_PULSE_NS 10000
`define DR_PULSE_CYC ((`DR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [core/diag_pkg.sv]
// Types shared by the status and diagnostics unit
package diag_pkg;
    typedef logic [15:0] word_t;
    typedef logic signed [13:0] sample_t;
    // Index 0 supply, 1 gyroscope, 2 auxiliary converter, 3 temperature
    typedef logic [3:0][13:0] sample_set_t;
    typedef enum {TEST_IDLE, TEST_RUN} test_state_t;
endpackage

// [core/sensor_status_diagnostics.sv]
// Status, self-test, flash count and alarm logic with its serial port
// Operation
// RL1: Data-ready line asserts whenever fresh output data arrives.
// RL2: Control bit 2 enables data-ready, bit 1 polarity, bit 0 line.
// RL3: Writing one to control bit 10 starts the internal self-test.
// RL4: Internal self-test outcome appears in error flag bit 5.
// RL5: Control bits 9 and 8 hold negative and positive external stimulus.
// RL6: Rate output follows external stimulus through the signal chain delay.
// RL7: Flags: bit 9/8 alarms, 4 over range, 3 link fail, 2 update fail.
// RL8: Flag 1 marks supply above limit, flag 0 supply below limit.
// RL9: Supply and over-range flags clear themselves when conditions end.
// RL10: Other flags stay set until the host reads the flag register.
// RL11: Reading the flag register returns it, then clears every bit (here bits 4, 1 and 0 keep following their inputs).
// RL12: A read-only register counts flash memory writes.
// RL13: Two independent alarms each watch a selectable output register.
// RL14: Each alarm compares filtered or unfiltered source data.
// RL15: Threshold has source format plus a greater/less direction bit.
// RL16: Sample count sets how many deltas are averaged in delta mode.
// RL17: Delta mode averages successive sample differences, then compares.
// RL18: Alarm control selects source, mode, filtering and line usage.
// RL19: Threshold bit 15 selects greater-than; bits 13 to 0 magnitude.
// RL20: Source codes: 1 supply, 2 gyro, 5 aux, 6 temperature, else off.
// RL21: Alarm control bit 2 enable, bit 1 polarity, bit 0 line.
// RL22: Line priority: general-purpose pins, then data-ready, then alarms.
// RL23: Writes to the flag and flash count registers change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "diag_consts.svh"

// Three-stage synchroniser; a change is taken once stages two and three agree
module sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                q <= s3_q;
        end
    end
endmodule

// One alarm comparator, static or averaged-delta
module alarm_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire diag_pkg::sample_set_t raw_data,
    input wire diag_pkg::sample_set_t filt_data,
    input wire logic use_filt,
    input wire logic [2:0] src_sel,
    input wire logic delta_compare_mode,
    input wire diag_pkg::word_t threshold,
    input wire logic [7:0] sample_count,
    output logic active
);
    import diag_pkg::*;

    logic sel_ok;
    logic [1:0] idx;
    sample_t cur;
    sample_t mag;
    logic greater;
    logic hit_static;
    logic signed [14:0] delta;
    logic signed [22:0] sum_next;
    logic signed [22:0] limit;
    logic [8:0] n_avg;
    logic last_delta;
    logic hit_delta;
    sample_t prev_q;
    logic have_prev_q;
    logic signed [22:0] sum_q;
    logic [7:0] cnt_q;

    assign sel_ok = (src_sel == `SRC_SUPPLY) || (src_sel == `SRC_GYRO) ||
                    (src_sel == `SRC_AUX) || (src_sel == `SRC_TEMP); // see RL20
    assign idx = (src_sel == `SRC_SUPPLY) ? 2'd0 :
                 (src_sel == `SRC_GYRO) ? 2'd1 :
                 (src_sel == `SRC_AUX) ? 2'd2 : 2'd3; // see RL13
    assign cur = use_filt ? filt_data[idx] : raw_data[idx]; // see RL14
    assign mag = threshold[`THR_MAG_HI:0]; // see RL15
    assign greater = threshold[`THR_DIR]; // see RL19
    assign hit_static = greater ? (cur > mag) : (cur < mag);
    // Successive difference, one bit wider so it cannot wrap
    assign delta = {cur[13], cur} - {prev_q[13], prev_q}; // see RL17
    assign sum_next = sum_q + 23'(delta);
    assign n_avg = (sample_count == 8'h00) ? 9'h001 : {1'b0, sample_count};
    assign last_delta = ({1'b0, cnt_q} + 9'h001) == n_avg; // see RL16
    // Mean compared as sum against threshold times count, avoiding a divider
    assign limit = 23'(mag) * $signed({14'h0000, n_avg});
    assign hit_delta = greater ? (sum_next > limit) : (sum_next < limit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= '0;
            have_prev_q <= 1'b0;
            sum_q <= '0;
            cnt_q <= 8'h00;
            active <= 1'b0;
        end
        else if (!sel_ok)
        begin
            have_prev_q <= 1'b0;
            sum_q <= '0;
            cnt_q <= 8'h00;
            active <= 1'b0;
        end
        else if (sample_valid)
        begin
            prev_q <= cur;
            have_prev_q <= 1'b1;
            if (!delta_compare_mode)
            begin
                active <= hit_static;
                sum_q <= '0;
                cnt_q <= 8'h00;
            end
            else if (have_prev_q && last_delta)
            begin
                active <= hit_delta; // see RL17
                sum_q <= '0;
                cnt_q <= 8'h00;
            end
            else if (have_prev_q)
            begin
                sum_q <= sum_next;
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

module sensor_status_diagnostics (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire diag_pkg::sample_set_t raw_data,
    input wire diag_pkg::sample_set_t filt_data,
    input wire logic supply_high,
    input wire logic supply_low,
    input wire logic rate_over_range,
    input wire logic ctrl_update_fail,
    input wire logic flash_write,
    input wire logic self_test_done,
    input wire logic self_test_fail,
    input wire logic [1:0] gpio_own,
    input wire logic [1:0] gpio_level,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic [1:0] dio_out,
    output logic [1:0] dio_oe,
    output logic self_test_start,
    output logic ext_test_pos,
    output logic ext_test_neg
);
    import diag_pkg::*;

    logic rst_s1_q;
    logic rst_sync_n;
    logic link_rst;
    logic [3:0] bit_cnt_q;
    logic [14:0] rx_q;
    word_t frame_q;
    logic done_tg_q;
    logic done_lvl;
    logic done_prev_q;
    logic frame_done;
    logic cs_lvl;
    logic cs_prev_q;
    logic cs_rise;
    logic cs_fall;
    logic got_frame_q;
    logic is_write;
    logic [5:0] addr;
    logic [5:0] word_addr;
    word_t wdat;
    word_t bmask;
    logic wr_diag;
    logic wr_actl;
    logic wr_thr1;
    logic wr_thr2;
    logic wr_smp1;
    logic wr_smp2;
    logic rd_flags;
    word_t diag_q;
    word_t alarm_control_q;
    word_t thr1_q;
    word_t thr2_q;
    word_t smpl1_q;
    word_t smpl2_q;
    word_t flags_q;
    word_t flags_d;
    word_t flag_set;
    word_t flag_clr;
    word_t flash_cnt_q;
    word_t rd_word_q;
    word_t rd_sel;
    word_t diag_view;
    test_state_t test_q;
    logic start_test;
    logic comm_fail;
    logic [7:0] dr_cnt_q;
    logic dr_active;
    logic alm1;
    logic alm2;
    logic alm_any;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // Link side: sample on rising edge, drive on falling edge
    assign link_rst = spi_cs_n | ~rst_sync_n;

    always_ff @(posedge spi_sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt_q <= 4'h0;
            rx_q <= 15'h0000;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            rx_q <= {rx_q[13:0], spi_mosi};
        end
    end

    always_ff @(posedge spi_sclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            frame_q <= 16'h0000;
            done_tg_q <= 1'b0;
        end
        else if (bit_cnt_q == 4'hf)
        begin
            frame_q <= {rx_q, spi_mosi};
            done_tg_q <= ~done_tg_q;
        end
    end

    // Reply word is held still by the core during a frame; it loads after a read frame
    always_ff @(negedge spi_sclk or posedge link_rst)
    begin
        if (link_rst)
            spi_miso <= 1'b0;
        else
            spi_miso <= rd_word_q[~bit_cnt_q];
    end

    sync3 done_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d(done_tg_q),
        .q(done_lvl)
    );

    sync3 cs_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d(~spi_cs_n),
        .q(cs_lvl)
    );

    assign frame_done = done_lvl ^ done_prev_q;
    assign cs_rise = cs_prev_q & ~cs_lvl;
    assign cs_fall = ~cs_prev_q & cs_lvl;
    // A select window that ends without a whole frame is a link failure
    assign comm_fail = cs_rise & ~got_frame_q & ~frame_done;

    // Frame decode
    assign is_write = frame_q[`FR_WRITE];
    assign addr = frame_q[`FR_ADDR_HI:`FR_ADDR_LO];
    assign word_addr = {addr[5:1], 1'b0};
    assign wdat = addr[0] ? {frame_q[7:0], 8'h00} : {8'h00, frame_q[7:0]};
    assign bmask = addr[0] ? 16'hff00 : 16'h00ff;
    assign wr_diag = frame_done & is_write & (word_addr == `ADDR_DIAG_CTRL);
    assign wr_actl = frame_done & is_write & (word_addr == `ADDR_ALARM_CONTROL);
    assign wr_thr1 = frame_done & is_write & (word_addr == `ADDR_ALM1_THR);
    assign wr_thr2 = frame_done & is_write & (word_addr == `ADDR_ALM2_THR);
    assign wr_smp1 = frame_done & is_write & (word_addr == `ADDR_ALM1_SMPL);
    assign wr_smp2 = frame_done & is_write & (word_addr == `ADDR_ALM2_SMPL);
    assign rd_flags = frame_done & ~is_write &
                      (word_addr == `ADDR_ERR_FLAGS); // see RL11

    assign start_test = wr_diag & (test_q == TEST_IDLE) &
                        wdat[`DC_INT_TEST] & bmask[`DC_INT_TEST]; // see RL3
    assign diag_view = diag_q |
                       {5'h00, test_q == TEST_RUN, 10'h000};

    // Flag and flash count registers take no write path
    assign rd_sel = (word_addr == `ADDR_FLASH_CNT) ? flash_cnt_q : // see RL12
                    (word_addr == `ADDR_DIAG_CTRL) ? diag_view :
                    (word_addr == `ADDR_ERR_FLAGS) ? flags_q :
                    (word_addr == `ADDR_ALARM_CONTROL) ? alarm_control_q :
                    (word_addr == `ADDR_ALM1_THR) ? thr1_q :
                    (word_addr == `ADDR_ALM2_THR) ? thr2_q :
                    (word_addr == `ADDR_ALM1_SMPL) ? smpl1_q :
                    (word_addr == `ADDR_ALM2_SMPL) ? smpl2_q : 16'h0000;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            done_prev_q <= 1'b0;
            cs_prev_q <= 1'b0;
            got_frame_q <= 1'b0;
            rd_word_q <= 16'h0000;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            done_prev_q <= done_lvl;
            cs_prev_q <= cs_lvl;
            spi_miso_oe <= cs_lvl;
            if (frame_done)
                got_frame_q <= 1'b1;
            else if (cs_fall)
                got_frame_q <= 1'b0;
            if (frame_done & ~is_write)
                rd_word_q <= rd_sel;
        end
    end

    // Control registers, written a byte at a time
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            diag_q <= `REG_RESET;
            alarm_control_q <= `REG_RESET;
            thr1_q <= `REG_RESET;
            thr2_q <= `REG_RESET;
            smpl1_q <= `REG_RESET;
            smpl2_q <= `REG_RESET;
        end
        else
        begin
            if (wr_diag)
                diag_q <= ((diag_q & ~bmask) | (wdat & bmask)) & `DIAG_MASK;
            if (wr_actl)
                alarm_control_q <= ((alarm_control_q & ~bmask) | (wdat & bmask)) &
                              `ALARM_CONTROL_MASK; // see RL18
            if (wr_thr1)
                thr1_q <= ((thr1_q & ~bmask) | (wdat & bmask)) & `THR_MASK;
            if (wr_thr2)
                thr2_q <= ((thr2_q & ~bmask) | (wdat & bmask)) & `THR_MASK;
            if (wr_smp1)
                smpl1_q <= ((smpl1_q & ~bmask) | (wdat & bmask)) & `SMPL_MASK;
            if (wr_smp2)
                smpl2_q <= ((smpl2_q & ~bmask) | (wdat & bmask)) & `SMPL_MASK;
        end
    end

    // Internal self-test handshake with the sensor
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            test_q <= TEST_IDLE;
            self_test_start <= 1'b0;
        end
        else
        begin
            self_test_start <= start_test; // see RL3
            case (test_q)
                TEST_IDLE:
                    if (start_test)
                        test_q <= TEST_RUN;
                TEST_RUN:
                    if (self_test_done)
                        test_q <= TEST_IDLE;
                default:
                    test_q <= TEST_IDLE;
            endcase
        end
    end

    // Static stimulus levels; the rate output settles downstream
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ext_test_pos <= 1'b0;
            ext_test_neg <= 1'b0;
        end
        else
        begin
            ext_test_pos <= diag_q[`DC_EXT_POS]; // see RL5 RL6
            ext_test_neg <= diag_q[`DC_EXT_NEG]; // see RL5
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    assign flag_set = {6'h00, alm2, alm1, 2'b00,
                       (test_q == TEST_RUN) & self_test_done & self_test_fail,
                       1'b0, comm_fail, ctrl_update_fail,
                       2'b00}; // see RL4 RL7
    assign flag_clr = rd_flags ? 16'hffff : 16'h0000; // see RL10 RL11

    always_comb
    begin
        flags_d = (flags_q & ~flag_clr) | flag_set;
        flags_d[`EF_OVER_RANGE] = rate_over_range; // see RL9
        flags_d[`EF_SUP_HIGH] = supply_high; // see RL8
        flags_d[`EF_SUP_LOW] = supply_low; // see RL8
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            flags_q <= `REG_RESET;
            flash_cnt_q <= 16'h0000;
        end
        else
        begin
            flags_q <= flags_d; // see RL23
            if (flash_write)
                flash_cnt_q <= flash_cnt_q + 16'h0001; // see RL12
        end
    end

    alarm_channel alarm_one (
        .clk(clk),
        .rst_n(rst_sync_n),
        .sample_valid(sample_valid),
        .raw_data(raw_data),
        .filt_data(filt_data),
        .use_filt(alarm_control_q[`AC_FILT]),
        .src_sel(alarm_control_q[`AC_SRC1_LO+2:`AC_SRC1_LO]),
        .delta_compare_mode(alarm_control_q[`AC_ROC1]),
        .threshold(thr1_q),
        .sample_count(smpl1_q[7:0]),
        .active(alm1)
    );

    alarm_channel alarm_two (
        .clk(clk),
        .rst_n(rst_sync_n),
        .sample_valid(sample_valid),
        .raw_data(raw_data),
        .filt_data(filt_data),
        .use_filt(alarm_control_q[`AC_FILT]),
        .src_sel(alarm_control_q[`AC_SRC2_LO+2:`AC_SRC2_LO]),
        .delta_compare_mode(alarm_control_q[`AC_ROC2]),
        .threshold(thr2_q),
        .sample_count(smpl2_q[7:0]),
        .active(alm2)
    );

    assign alm_any = alm1 | alm2;
    assign dr_active = dr_cnt_q != 8'h00;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            dr_cnt_q <= 8'h00;
        else if (sample_valid)
            dr_cnt_q <= 8'(`DR_PULSE_CYC); // see RL1
        else if (dr_active)
            dr_cnt_q <= dr_cnt_q - 8'h01;
    end

    // Digital line arbitration per line
    for (genvar i = 0; i < 2; i++)
    begin : g_line
        logic dr_here;
        logic alm_here;
        assign dr_here = diag_q[`DC_DR_EN] &
                         (diag_q[`DC_DR_LINE] == 1'(i)); // see RL2
        assign alm_here = alarm_control_q[`AC_EN] &
                          (alarm_control_q[`AC_LINE] == 1'(i)); // see RL21

        always_ff @(posedge clk or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
            begin
                dio_out[i] <= 1'b0;
                dio_oe[i] <= 1'b0;
            end
            else if (gpio_own[i]) // see RL22
            begin
                dio_out[i] <= gpio_level[i];
                dio_oe[i] <= 1'b1;
            end
            else if (dr_here)
            begin
                dio_out[i] <= ~(dr_active ^ diag_q[`DC_DR_POL]); // see RL2
                dio_oe[i] <= 1'b1;
            end
            else if (alm_here)
            begin
                dio_out[i] <= ~(alm_any ^ alarm_control_q[`AC_POL]); // see RL21
                dio_oe[i] <= 1'b1;
            end
            else
            begin
                dio_out[i] <= 1'b0;
                dio_oe[i] <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// [sim/sensor_status_diagnostics_sva.sv]
// Port checks on the diagnostics unit
`timescale 1ns/1ps
`default_nettype none
module sensor_status_diagnostics_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic [1:0] gpio_own,
    input wire logic [1:0] gpio_level,
    input wire logic [1:0] dio_out,
    input wire logic [1:0] dio_oe,
    input wire logic self_test_start,
    input wire logic ext_test_pos,
    input wire logic ext_test_neg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_start_one;
        self_test_start |=> !self_test_start;
    endproperty
    a_start_one: assert property (p_start_one)
        else $error("start pulse too long");
    property p_start_quiet;
        spi_cs_n [*8] |-> !self_test_start;
    endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("stray start pulse");
    property p_ext_hold;
        spi_cs_n [*8] |-> $stable(ext_test_pos) && $stable(ext_test_neg);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("stray stimulus change");
    property p_gpio0;
        (gpio_own[0] && $stable(gpio_level[0])) [*3] |->
            dio_out[0] == gpio_level[0];
    endproperty
    a_gpio0: assert property (p_gpio0)
        else $error("line 0 not owner level");
    property p_gpio1;
        (gpio_own[1] && $stable(gpio_level[1])) [*3] |->
            dio_out[1] == gpio_level[1];
    endproperty
    a_gpio1: assert property (p_gpio1)
        else $error("line 1 not owner level");
    property p_idle_low;
        (dio_out & ~dio_oe) == 2'h0;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("undriven line high");
    property p_miso_idle;
        spi_cs_n [*2] |-> !spi_miso;
    endproperty
    a_miso_idle: assert property (p_miso_idle)
        else $error("reply while idle");
    property p_oe_off;
        spi_cs_n [*6] |-> !spi_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("enable while idle");
    property p_oe_on;
        !spi_cs_n [*6] |-> spi_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("enable off in frame");
endmodule
bind sensor_status_diagnostics sensor_status_diagnostics_sva i_sva (
    .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .gpio_own(gpio_own),
    .gpio_level(gpio_level), .dio_out(dio_out), .dio_oe(dio_oe),
    .self_test_start(self_test_start), .ext_test_pos(ext_test_pos),
    .ext_test_neg(ext_test_neg)
);
`default_nettype wire

// [sim/spi_host.sv]
// Host serial master model
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial
        {sclk, cs_n, mosi} = 3'h7;
    // One 16-bit frame; clock idles high
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            #3 sclk = 1'b0;
            mosi = tx[i];
            #3 sclk = 1'b1;
            rx[i] = miso;
        end
        #3 mosi = ~mosi;
        #400 cs_n = 1'b1;
        #400;
    endtask
    // Select pulse with no clocks
    task automatic abort();
        cs_n = 1'b0;
        #400 cs_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// [sim/sensor_status_diagnostics_test.sv]
// Self-checking bench for the diagnostics unit
`timescale 1ns/1ps
`default_nettype none
module sensor_status_diagnostics_test;
    import diag_pkg::*;
    logic clk, rst_n, sample_valid, supply_high, supply_low;
    logic rate_over_range, ctrl_update_fail, flash_write;
    logic self_test_done, self_test_fail, st_start, ext_pos, ext_neg;
    logic sclk, cs_n, mosi, miso;
    logic st_seen = 1'b0;
    sample_set_t raw_data, filt_data;
    logic [1:0] gpio_own, gpio_level, dio_out, dio_oe;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    sensor_status_diagnostics i_dut (
        .clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
        .raw_data(raw_data), .filt_data(filt_data),
        .supply_high(supply_high), .supply_low(supply_low),
        .rate_over_range(rate_over_range),
        .ctrl_update_fail(ctrl_update_fail), .flash_write(flash_write),
        .self_test_done(self_test_done), .self_test_fail(self_test_fail),
        .gpio_own(gpio_own), .gpio_level(gpio_level), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe(), .dio_out(dio_out), .dio_oe(dio_oe),
        .self_test_start(st_start), .ext_test_pos(ext_pos),
        .ext_test_neg(ext_neg)
    );
    spi_host i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (st_start === 1'b1)
            st_seen = 1'b1;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] rx;
        i_host.xfer({2'b10, a, d}, rx);
    endtask
    // Reply on the next frame
    task automatic rd(input logic [5:0] a, output logic [15:0] v);
        i_host.xfer({2'b00, a, 8'h00}, v);
        i_host.xfer(16'h0000, v);
    endtask
    task automatic smp(input sample_set_t r, input sample_set_t f);
        @(negedge clk);
        raw_data = r;
        filt_data = f;
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        tick(4);
    endtask
    task automatic t_flags();
        logic [15:0] v;
        rd(6'h34, v);
        chk(v, 16'h0000);
        tick(1);
        {supply_high, supply_low, rate_over_range, ctrl_update_fail} = 4'hf;
        tick(1);
        ctrl_update_fail = 1'b0;
        i_host.abort();
        rd(6'h3c, v);
        chk(v, 16'h001f);
        tick(1);
        {supply_high, rate_over_range} = 2'h0;
        wr(6'h3c, 8'hff);
        wr(6'h3d, 8'hff);
        rd(6'h3c, v);
        chk(v, 16'h0001);
        tick(1);
        supply_low = 1'b0;
        tick(2);
        rd(6'h3c, v);
        chk(v, 16'h0000);
    endtask
    task automatic t_flash();
        logic [15:0] v;
        repeat (3)
        begin
            tick(1);
            flash_write = 1'b1;
            tick(1);
            flash_write = 1'b0;
        end
        wr(6'h00, 8'hff);
        wr(6'h01, 8'hff);
        rd(6'h00, v);
        chk(v, 16'h0003);
    endtask
    task automatic t_self_test();
        logic [15:0] v;
        wr(6'h35, 8'h04);
        rd(6'h34, v);
        chk(v, 16'h0400);
        chk(16'(st_seen), 16'h0001);
        tick(1);
        {self_test_done, self_test_fail} = 2'h3;
        tick(1);
        {self_test_done, self_test_fail} = 2'h0;
        tick(2);
        rd(6'h3c, v);
        chk(v, 16'h0020);
        wr(6'h35, 8'h03);
        chk({14'h0, ext_neg, ext_pos}, 16'h0003);
        wr(6'h35, 8'h01);
        chk({14'h0, ext_neg, ext_pos}, 16'h0001);
        rd(6'h34, v);
        chk(v, 16'h0100);
        wr(6'h35, 8'h00);
    endtask
    task automatic t_ready();
        logic [1:0] ln;
        for (int k = 0; k < 4; k++)
        begin
            ln = 2'b01 << k[0];
            wr(6'h34, 8'(4 + k));
            smp('0, '0);
            chk(16'(dio_oe), 16'(ln));
            chk(16'(dio_out), k[1] ? 16'(ln) : 16'h0);
            tick(200);
            chk(16'(dio_out), k[1] ? 16'h0 : 16'(ln));
        end
        wr(6'h34, 8'h04);
        tick(1);
        {gpio_own, gpio_level} = 4'hc;
        tick(5);
        chk(16'(dio_out), 16'h0000);
        chk(16'(dio_oe), 16'h0003);
        gpio_own = 2'h0;
        wr(6'h34, 8'h00);
    endtask
    task automatic t_alarm();
        logic [15:0] v;
        logic hit;
        sample_set_t f;
        wr(6'h20, 8'd100);
        wr(6'h21, 8'h80);
        wr(6'h29, 8'h02);
        wr(6'h28, 8'h16);
        smp({14'd0, 14'd0, 14'd200, 14'd0}, '0);
        chk(16'(dio_out), 16'h0000);
        for (int c = 0; c < 8; c++)
        begin
            wr(6'h29, 8'(c));
            hit = (c == 1 || c == 2 || c == 5 || c == 6);
            f = hit ? '0 : {4{14'd200}};
            f[c == 1 ? 0 : c == 2 ? 1 : c == 5 ? 2 : 3] = 14'd200;
            smp('0, f);
            chk(16'(dio_out), 16'(hit));
            smp('0, '0);
        end
        rd(6'h3c, v);
        chk(v, 16'h0100);
        wr(6'h22, 8'hfb);
        wr(6'h23, 8'h3f);
        wr(6'h26, 8'h02);
        wr(6'h29, 8'he2);
        for (int s = 100; s > 70; s -= 10)
            smp('0, {14'(s), 42'd0});
        chk(16'(dio_out), 16'h0001);
        rd(6'h3c, v);
        chk(v, 16'h0200);
    endtask
    initial
    begin
        rst_n = 1'b0;
        {sample_valid, supply_high, supply_low, rate_over_range} = 4'h0;
        {ctrl_update_fail, flash_write, self_test_done} = 3'h0;
        {self_test_fail, gpio_own, gpio_level, raw_data, filt_data} = '0;
        tick(2);
        rst_n = 1'b1;
        tick(5);
        t_flags();
        t_flash();
        t_self_test();
        t_ready();
        t_alarm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
